// File: rtl/pfs_pkg.sv
/*
 * Shared definitions for the panel pixel-format and shift-clock block:
 * register map, configuration field layout, mode and pixel types.
 * Assumes a 32-bit register word and a 6:6:6 pixel source.
 */
package pfs_pkg;

	// ==================================================================
	// register map
	localparam int unsigned REG_AW        = 4;
	localparam int unsigned REG_DW        = 32;
	localparam logic [3:0]  CFG_ADDR      = 4'h0;
	localparam logic [3:0]  STAT_ADDR     = 4'h4;
	localparam int unsigned FMT_LSB       = 16;
	localparam int unsigned STAT_PEND_BIT = 0;
	localparam int unsigned STAT_MODE_LSB = 4;

	// ==================================================================
	// configuration codes
	localparam logic [2:0] FMT_000 = 3'h0;
	localparam logic [2:0] FMT_001 = 3'h1;
	localparam logic [2:0] FMT_010 = 3'h2;
	localparam logic [2:0] FMT_011 = 3'h3;
	localparam logic [1:0] TYPE_STN = 2'h0;
	localparam logic [1:0] TYPE_TFT = 2'h1;
	localparam logic       SEL_COLOUR = 1'b0;
	localparam logic       SEL_MONO   = 1'b1;

	// field order matches word bits 21:16
	typedef struct packed {
		logic [1:0] panel_type_select;
		logic       mono;
		logic [2:0] pixel_output_format;
	} pfs_cfg_t;
	localparam int unsigned CFG_W     = $bits(pfs_cfg_t);
	localparam pfs_cfg_t    CFG_RESET = '0;

	typedef enum logic [2:0] {
		MODE_IDLE, MODE_M8D, MODE_TFT1, MODE_C16D,
		MODE_M16D, MODE_TFT2, MODE_C24D, MODE_C8S
	} pfs_mode_t;

	typedef struct packed { logic [5:0] r; logic [5:0] g; logic [5:0] b; } pfs_px_t;
	typedef struct packed { pfs_px_t upper; pfs_px_t lower; } pfs_dual_t;
	localparam int unsigned COMP_MSB = 5;

	// ==================================================================
	// data path sizes: bits per dot, bits per shift
	localparam int unsigned HOLD_W  = 48;
	localparam int unsigned PANEL_W = 36;
	localparam int unsigned B_MONO  = 2;
	localparam int unsigned B_SST   = 3;
	localparam int unsigned B_CLR   = 6;
	localparam int unsigned B_TFT   = 18;
	localparam int unsigned W_M8    = 8;
	localparam int unsigned W_M16   = 16;
	localparam int unsigned W_C24   = 24;
	localparam int unsigned W_C16   = 16;
	localparam int unsigned W_SST   = 8;
	localparam int unsigned W_TFT2  = 36;
	localparam int unsigned PH_SLICES = 3;
	localparam logic [1:0]  PH_LAST_323 = 2'h2;
	localparam logic [3:0]  LEN_1 = 4'h1;
	localparam logic [3:0]  LEN_2 = 4'h2;
	localparam logic [3:0]  LEN_3 = 4'h3;
	localparam logic [3:0]  LEN_4 = 4'h4;
	localparam logic [3:0]  LEN_8 = 4'h8;

	// unsupported or reserved combinations fall to idle
	function automatic pfs_mode_t pfs_decode(input pfs_cfg_t c);
		pfs_mode_t m;
		m = MODE_IDLE;
		if (c.panel_type_select == TYPE_STN)
		begin
			case (c.pixel_output_format)
				FMT_000: m = c.mono ? MODE_M8D : MODE_IDLE;
				FMT_001: m = c.mono ? MODE_M16D : MODE_C16D;
				FMT_010: m = c.mono ? MODE_IDLE : MODE_C24D;
				FMT_011: m = c.mono ? MODE_IDLE : MODE_C8S;
				default: m = MODE_IDLE;
			endcase
		end
		else if (c.panel_type_select == TYPE_TFT && c.mono == SEL_COLOUR)
		begin
			case (c.pixel_output_format)
				FMT_000: m = MODE_TFT1;
				FMT_001: m = MODE_TFT2;
				default: m = MODE_IDLE;
			endcase
		end
		return m;
	endfunction

	// dot clocks per shift period; phase 1 of the 3:2:3 pattern is short
	function automatic logic [3:0] pfs_period_len(input pfs_mode_t m, input logic [1:0] ph);
		logic [3:0] n;
		n = LEN_1;
		case (m)
			MODE_M8D, MODE_C24D: n = LEN_4;
			MODE_M16D:           n = LEN_8;
			MODE_TFT2:           n = LEN_2;
			MODE_C16D, MODE_C8S: n = (ph == 2'h1) ? LEN_2 : LEN_3;
			default:             n = LEN_1;
		endcase
		return n;
	endfunction

endpackage

// File: rtl/pfs_panel_format.sv
/*
 * Panel pixel-format and shift-clock generator. Register side on mclk_in,
 * panel side on the pixel dot clock; configuration crosses by a toggle
 * handshake. Assumes the pixel source is synchronous to the dot clock and
 * supplies upper and lower half pixels together for dual-scan panels.
 */
// Function
// R1 - format, type, colour choose layout and rate
// R2 - 000 STN mono: 8-bit dual, shift/4
// R3 - software avoids 8-bit colour dual-scan
// R4 - 000 TFT colour: one pixel, dot rate
// R5 - 001 STN colour: 16-bit dual, 3:2:3
// R6 - 001 STN mono: 16-bit dual, shift/8
// R7 - 001 TFT colour: two pixels, half rate
// R8 - 010 STN colour: 24-bit dual, shift/4
// R9 - software avoids mono 24-bit dual-scan
// R10 - 011 STN colour: 8-bit single scan
// R11 - panel type 00 STN, 01 TFT
// R12 - colour select 0 colour, 1 mono
// R13 - 8-bit single scan uses 3:2:3 too
// R14 - software avoids formats 100 to 111
// R15 - 3:2:3 means periods 3,2,3 dots
// R16 - unsupported setups hold clock, data idle
`timescale 1ns/10ps
module pfs_panel_format
(
	input  wire logic                        mclk_in,
	input  wire logic                        rst_in,
	input  wire logic [pfs_pkg::REG_AW-1:0]  reg_addr_in,
	input  wire logic [pfs_pkg::REG_DW-1:0]  reg_wdata_in,
	input  wire logic                        reg_wr_in,
	input  wire logic                        reg_rd_in,
	output logic      [pfs_pkg::REG_DW-1:0]  reg_rdata_out,
	input  wire logic                        pixel_dot_clock_in,
	input  wire pfs_pkg::pfs_dual_t          pix_in,
	input  wire logic                        pix_valid_in,
	output logic                             panel_shift_clock_out,
	output logic      [pfs_pkg::PANEL_W-1:0] panel_data_out
);
	import pfs_pkg::*;

	// ==================================================================
	// register side (mclk)
	pfs_cfg_t            cfg_q;
	pfs_cfg_t            send_q;
	pfs_cfg_t            applied_q;
	logic                req_tog_q;
	logic                ack_s1_q;
	logic                ack_s2_q;
	logic [REG_DW-1:0]   rdata_q;
	logic                ack_tog_q;
	pfs_mode_t           applied_mode;
	logic [REG_DW-1:0]   rd_word;
	logic                wr_cfg;
	logic                busy;
	logic                launch;
	logic                pending;

	// decode and handshake state
	assign wr_cfg       = reg_wr_in && (reg_addr_in == CFG_ADDR);
	assign busy         = req_tog_q != ack_s2_q;
	assign launch       = !busy && (cfg_q != send_q);
	// pending also covers the cycle before applied_q takes the new word
	assign pending      = busy || (cfg_q != send_q) || (applied_q != send_q);
	assign applied_mode = pfs_decode(applied_q);
	assign rd_word      = (reg_addr_in == CFG_ADDR) ? (REG_DW'(cfg_q) << FMT_LSB) :
		(reg_addr_in == STAT_ADDR) ? ((REG_DW'(pending) << STAT_PEND_BIT) |
		(REG_DW'(applied_mode) << STAT_MODE_LSB)) : '0;
	assign reg_rdata_out = rdata_q;

	// config word is held in send_q while a transfer is in flight
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			cfg_q     <= CFG_RESET;
			send_q    <= CFG_RESET;
			applied_q <= CFG_RESET;
			req_tog_q <= 1'b0;
			ack_s1_q  <= 1'b0;
			ack_s2_q  <= 1'b0;
			rdata_q   <= '0;
		end
		else
		begin
			if (wr_cfg)
				cfg_q <= pfs_cfg_t'(reg_wdata_in[FMT_LSB +: CFG_W]); // R1
			if (launch)
			begin
				send_q    <= cfg_q;
				req_tog_q <= ~req_tog_q;
			end
			ack_s1_q <= ack_tog_q;
			ack_s2_q <= ack_s1_q;
			if (!busy)
				applied_q <= send_q;
			rdata_q <= reg_rd_in ? rd_word : '0;
		end
	end

	// ==================================================================
	// dot clock domain: reset and config capture
	logic                drst_s1_q;
	logic                drst_s2_q;
	logic                req_s1_q;
	logic                req_s2_q;
	logic                req_s3_q;
	pfs_cfg_t            dcfg_q;
	pfs_mode_t           dmode;

	// reset reaches the dot side through two flops, so it ends cleanly there
	always_ff @(posedge pixel_dot_clock_in)
	begin
		drst_s1_q <= rst_in;
		drst_s2_q <= drst_s1_q;
	end

	// send_q is stable while the request toggle is visible here
	always_ff @(posedge pixel_dot_clock_in)
	begin
		if (drst_s2_q)
		begin
			req_s1_q  <= 1'b0;
			req_s2_q  <= 1'b0;
			req_s3_q  <= 1'b0;
			ack_tog_q <= 1'b0;
			dcfg_q    <= CFG_RESET;
		end
		else
		begin
			req_s1_q  <= req_tog_q;
			req_s2_q  <= req_s1_q;
			req_s3_q  <= req_s2_q;
			ack_tog_q <= req_s2_q;
			if (req_s2_q != req_s3_q)
				dcfg_q <= send_q;
		end
	end

	// ==================================================================
	// shift period sequencing
	logic [3:0]          cnt_q;
	logic [3:0]          cnt_d;
	logic [1:0]          ph_q;
	logic [1:0]          ph_d;
	logic [3:0]          per_len;
	logic [3:0]          len_d;
	logic [1:0]          last_ph;
	logic                run;
	logic                is323;
	logic                period_end;
	logic                pattern_end;
	logic                shclk_q;
	logic                shclk_d;
	logic                tft_gate_q;

	// mode decode and counter next state; a config change does not restart them
	assign dmode       = pfs_decode(dcfg_q); // R11 R12
	assign run         = pix_valid_in && (dmode != MODE_IDLE); // R16
	assign is323       = (dmode == MODE_C16D) || (dmode == MODE_C8S); // R5 R13
	assign last_ph     = is323 ? PH_LAST_323 : 2'h0; // R15
	assign per_len     = pfs_period_len(dmode, ph_q); // R2 R6 R7 R8 R15
	assign period_end  = run && (cnt_q == (per_len - LEN_1));
	assign pattern_end = period_end && (ph_q == last_ph);
	assign cnt_d       = (!run || period_end) ? 4'h0 : (cnt_q + LEN_1);
	assign ph_d        = (!run || pattern_end) ? 2'h0 : (period_end ? (ph_q + 2'h1) : ph_q);
	assign len_d       = pfs_period_len(dmode, ph_d);
	// high for the first half period, the odd dot goes to the low half
	assign shclk_d     = run && (cnt_d < (len_d >> 1));

	// counter, phase and shift clock move together, so the clock has no glitch
	always_ff @(posedge pixel_dot_clock_in)
	begin
		if (drst_s2_q)
		begin
			cnt_q   <= 4'h0;
			ph_q    <= 2'h0;
			shclk_q <= 1'b0;
		end
		else
		begin
			cnt_q   <= cnt_d;
			ph_q    <= ph_d;
			shclk_q <= shclk_d;
		end
	end

	// full-rate shift clock can only be a gated dot clock; the gate moves
	// on the falling edge so no runt pulse reaches the panel
	always_ff @(negedge pixel_dot_clock_in)
	begin
		if (drst_s2_q)
			tft_gate_q <= 1'b0;
		else
			tft_gate_q <= run && (dmode == MODE_TFT1); // R4
	end

	assign panel_shift_clock_out = (pixel_dot_clock_in & tft_gate_q) | shclk_q;

	// ==================================================================
	// pixel packing: collect one pattern, present it a shift at a time
	logic [HOLD_W-1:0]   acc_q;
	logic [HOLD_W-1:0]   acc_d;
	logic [HOLD_W-1:0]   hold_q;
	logic [HOLD_W-1:0]   hold_d;
	logic [PANEL_W-1:0]  data_q;
	logic [PANEL_W-1:0]  data_d;
	logic [B_MONO-1:0]   mono_bits;
	logic [B_SST-1:0]    up_rgb;
	logic [B_CLR-1:0]    dual_rgb;

	// dithering is outside; the component MSB stands for the pixel
	assign up_rgb    = {pix_in.upper.r[COMP_MSB], pix_in.upper.g[COMP_MSB],
		pix_in.upper.b[COMP_MSB]};
	assign dual_rgb  = {up_rgb, pix_in.lower.r[COMP_MSB], pix_in.lower.g[COMP_MSB],
		pix_in.lower.b[COMP_MSB]};
	assign mono_bits = {pix_in.upper.g[COMP_MSB], pix_in.lower.g[COMP_MSB]};
	assign hold_d    = pattern_end ? acc_d : hold_q;

	// each dot appends at the LSB side, so the earliest dot ends in the MSBs
	always_comb
	begin
		acc_d = '0;
		if (run)
		begin
			case (dmode)
				MODE_M8D, MODE_M16D:  acc_d = {acc_q[HOLD_W-B_MONO-1:0], mono_bits}; // R2 R6
				MODE_C16D, MODE_C24D: acc_d = {acc_q[HOLD_W-B_CLR-1:0], dual_rgb}; // R5 R8
				MODE_C8S:             acc_d = {acc_q[HOLD_W-B_SST-1:0], up_rgb}; // R10
				MODE_TFT1, MODE_TFT2: acc_d = {acc_q[HOLD_W-B_TFT-1:0], pix_in.upper}; // R4 R7
				default:              acc_d = '0;
			endcase
		end
	end

	// slice for the shift period that starts next
	always_comb
	begin
		data_d = '0;
		case (dmode)
			MODE_M8D:  data_d = PANEL_W'(hold_d[W_M8-1:0]); // R2
			MODE_M16D: data_d = PANEL_W'(hold_d[W_M16-1:0]); // R6
			MODE_C24D: data_d = PANEL_W'(hold_d[W_C24-1:0]); // R8
			MODE_TFT1: data_d = PANEL_W'(hold_d[B_TFT-1:0]); // R4
			MODE_TFT2: data_d = PANEL_W'(hold_d[W_TFT2-1:0]); // R7
			MODE_C16D: data_d = PANEL_W'(hold_d[W_C16*(PH_SLICES-int'(ph_d))-1 -: W_C16]); // R5
			MODE_C8S:  data_d = PANEL_W'(hold_d[W_SST*(PH_SLICES-int'(ph_d))-1 -: W_SST]); // R10
			default:   data_d = '0;
		endcase
	end

	// data move only at a period end or when idle clears them, so each word stands a whole period
	always_ff @(posedge pixel_dot_clock_in)
	begin
		if (drst_s2_q)
		begin
			acc_q  <= '0;
			hold_q <= '0;
			data_q <= '0;
		end
		else
		begin
			acc_q  <= pattern_end ? '0 : acc_d;
			hold_q <= hold_d;
			if (dmode == MODE_IDLE)
				data_q <= '0; // R16
			else if (period_end)
				data_q <= data_d;
		end
	end

	assign panel_data_out = data_q;

	// ==================================================================
	// checks
	a_cfg_hold_busy: assert property (@(posedge mclk_in) disable iff (rst_in) // R1
		busy |=> $stable(send_q))
		else $error("config word changed during crossing");

	a_mono8_period: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R2
		(dmode == MODE_M8D && period_end) ##1 (run && dmode == MODE_M8D && !period_end)[*3]
		##1 (run && dmode == MODE_M8D) |-> period_end)
		else $error("mono 8-bit shift period not four dots");

	a_tft1_full_rate: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R4
		(run && dmode == MODE_TFT1) ##1 (run && dmode == MODE_TFT1) |-> tft_gate_q && !shclk_q)
		else $error("one pixel tft shift clock not gated dot clock");

	a_c323_long_phase: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R5
		(is323 && period_end && ph_q == 2'h2) ##1 (run && is323 && !period_end)[*2]
		##1 (run && is323) |-> period_end && ph_q == 2'h0)
		else $error("3:2:3 first period not three dots");

	a_c323_short_phase: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R13
		(is323 && period_end && ph_q == 2'h0) ##1 (run && is323 && !period_end)
		##1 (run && is323) |-> period_end && ph_q == 2'h1)
		else $error("3:2:3 middle period not two dots");

	a_mono16_period: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R6
		(dmode == MODE_M16D && period_end) ##1 (run && dmode == MODE_M16D && !period_end)[*7]
		##1 (run && dmode == MODE_M16D) |-> period_end)
		else $error("mono 16-bit shift period not eight dots");

	a_tft2_half_rate: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R7
		(dmode == MODE_TFT2 && period_end) ##1 (run && dmode == MODE_TFT2)
		|-> !period_end ##1 (run && dmode == MODE_TFT2 && period_end) || !run)
		else $error("two pixel tft shift period not two dots");

	a_c24_period: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R8
		(dmode == MODE_C24D && period_end) ##1 (run && dmode == MODE_C24D && !period_end)[*3]
		##1 (run && dmode == MODE_C24D) |-> period_end)
		else $error("colour 24-bit shift period not four dots");

	a_sstn_width: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R10
		(dmode == MODE_C8S && period_end) |=> data_q[PANEL_W-1:W_SST] == '0)
		else $error("single scan data wider than eight bits");

	a_idle_quiet: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R16
		(dmode == MODE_IDLE) |=> !shclk_q && !tft_gate_q && data_q == '0)
		else $error("unsupported setup left clock or data active");

	a_rdata_one_cycle: assert property (@(posedge mclk_in) disable iff (rst_in) // R1
		!reg_rd_in |=> reg_rdata_out == '0)
		else $error("read data stood longer than one cycle");

	a_period_rise: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R15
		(period_end && dmode != MODE_TFT1) |=> shclk_q)
		else $error("shift clock not high at start of period");

	a_tft1_every_dot: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R4
		(run && dmode == MODE_TFT1) |-> period_end)
		else $error("one pixel tft period longer than one dot");

	a_type_reserved: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R11
		(dcfg_q.panel_type_select != TYPE_STN && dcfg_q.panel_type_select != TYPE_TFT)
		|-> dmode == MODE_IDLE)
		else $error("reserved panel type not idle");

	a_mono_select: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R12
		(dcfg_q.mono == SEL_MONO) |-> (dmode == MODE_IDLE || dmode == MODE_M8D
		|| dmode == MODE_M16D))
		else $error("mono select drove a colour arrangement");

	a_shclk_invalid: assert property (@(posedge pixel_dot_clock_in) disable iff (drst_s2_q) // R16
		!pix_valid_in |=> !shclk_q)
		else $error("shift clock ran without valid pixels");

endmodule // pfs_panel_format

// File: tb/pfs_panel_model.sv
/*
 * Panel receiver model: times each shift-clock rise in dot clocks and
 * latches the panel data at that rise. Assumes a free-running dot clock.
 */
`timescale 1ns/10ps
module pfs_panel_model
(
	input  wire logic        dot_in,
	input  wire logic        shclk_in,
	input  wire logic [35:0] data_in,
	output int               rises_out,
	output int               per0_out,
	output int               per1_out,
	output int               per2_out,
	output logic [35:0]      data_out
);
	logic prev;
	int   cnt;

	initial
	begin
		rises_out = 0;
		per0_out = 0;
		per1_out = 0;
		per2_out = 0;
		data_out = '0;
		cnt = 0;
		prev = 1'b0;
		// one process owns every output; sampling in both dot phases lets
		// a gated dot-rate clock still show its edges
		forever
		begin
			@(posedge dot_in);
			#20;
			cnt = cnt + 1;
			if (shclk_in === 1'b1 && prev === 1'b0)
			begin
				per2_out = per1_out;
				per1_out = per0_out;
				per0_out = cnt;
				cnt = 0;
				rises_out = rises_out + 1;
				data_out = data_in;
			end
			prev = shclk_in;
			#40;
			prev = shclk_in;
		end
	end
endmodule // pfs_panel_model

// File: tb/pfs_panel_format_tb_top.sv
/*
 * Self-checking bench for the panel format block: walks every format,
 * type and colour setting with random pixels. Assumes the panel model.
 */
`timescale 1ns/10ps
module pfs_panel_format_tb_top;
	import pfs_pkg::*;

	logic        mclk_in, rst_in, reg_wr_in, reg_rd_in, pixel_dot_clock_in, pix_valid_in;
	logic [3:0]  reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_out, d0;
	pfs_dual_t   pix_in;
	logic        panel_shift_clock_out;
	logic [35:0] panel_data_out, mdl_data;
	int          rises, per0, per1, per2, base, err_total, n_tests, c;
	logic [5:0]  last_cf;

	pfs_panel_format u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .pixel_dot_clock_in(pixel_dot_clock_in),
		.pix_in(pix_in), .pix_valid_in(pix_valid_in),
		.panel_shift_clock_out(panel_shift_clock_out), .panel_data_out(panel_data_out));

	pfs_panel_model u_panel (.dot_in(pixel_dot_clock_in), .shclk_in(panel_shift_clock_out),
		.data_in(panel_data_out), .rises_out(rises), .per0_out(per0), .per1_out(per1),
		.per2_out(per2), .data_out(mdl_data));

	// ==================================================================
	// clocks: the dot clock is offset so the two never line up
	initial
	begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	initial
	begin
		pixel_dot_clock_in = 1'b0;
		#3;
		forever #40 pixel_dot_clock_in = ~pixel_dot_clock_in;
	end

	// ==================================================================
	// checking and register bus tasks
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons=%0d mismatches=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask

	// pending must clear well inside the bound, or the run is cut short
	task automatic wait_applied();
		logic [31:0] d;
		int          k;
		for (k = 0; k < 300; k++)
		begin
			reg_rd(STAT_ADDR, d);
			if (d[0] === 1'b0)
				break;
		end
		if (k == 300)
		begin
			check(d[0], 1'b0);
			tally_and_finish();
		end
	endtask

	// ==================================================================
	// expected mode and panel word, worked out independently
	function automatic pfs_mode_t exp_mode(input logic [5:0] c);
		case (c)
			6'h08:   return MODE_M8D;
			6'h10:   return MODE_TFT1;
			6'h01:   return MODE_C16D;
			6'h09:   return MODE_M16D;
			6'h11:   return MODE_TFT2;
			6'h02:   return MODE_C24D;
			6'h03:   return MODE_C8S;
			default: return MODE_IDLE;
		endcase
	endfunction

	function automatic logic [35:0] exp_data(input pfs_mode_t m, input pfs_dual_t p);
		logic [1:0] mo;
		logic [5:0] six;
		mo = {p.upper.g[5], p.lower.g[5]};
		six = {p.upper.r[5], p.upper.g[5], p.upper.b[5], p.lower.r[5], p.lower.g[5], p.lower.b[5]};
		case (m)
			MODE_M8D:  return {28'h0000000, {4{mo}}};
			MODE_M16D: return {20'h00000, {8{mo}}};
			MODE_C24D: return {12'h000, {4{six}}};
			MODE_C16D: return {20'h00000, {16{p[35]}}};
			MODE_C8S:  return {28'h0000000, {8{p[35]}}};
			MODE_TFT1: return {18'h00000, p.upper};
			MODE_TFT2: return {p.upper, p.upper};
			default:   return 36'h000000000;
		endcase
	endfunction

	// len 0 idle, 3 the 3:2:3 pattern, else a fixed period in dots
	task automatic chk_run(input int len, input logic [35:0] ed);
		if (len == 0)
			check(rises - base, 0);
		else if (len == 3)
		begin
			check(per0 + per1 + per2, 8);
			check((per0 == 2) + (per1 == 2) + (per2 == 2), 1);
		end
		else
		begin
			check(per0, len);
			check(per1, len);
		end
		check((len == 0) ? panel_data_out : mdl_data, ed);
	endtask

	// ==================================================================
	// one setting: program, confirm, stream a constant random pixel
	task automatic run_cfg(input logic [5:0] cf);
		logic [31:0] d;
		logic [63:0] r;
		pfs_dual_t   p;
		pfs_mode_t   m;
		m = exp_mode(cf);
		d = $urandom;
		d[21:16] = cf;
		reg_wr(CFG_ADDR, d);
		reg_rd(STAT_ADDR, d);
		// rewriting the setting already in force leaves nothing pending
		check(d[0], cf != last_cf);
		last_cf = cf;
		wait_applied();
		reg_rd(CFG_ADDR, d);
		check(d, {10'h000, cf, 16'h0000});
		reg_rd(STAT_ADDR, d);
		check(d[6:4], m);
		r = {$urandom, $urandom};
		p = r[35:0];
		// slices of the 3:2:3 word only line up when all six component MSBs agree
		if (m == MODE_C16D || m == MODE_C8S)
			p = p[35] ? (p | 36'h820820820) : (p & ~36'h820820820);
		base = rises;
		@(posedge pixel_dot_clock_in);
		pix_in <= p;
		pix_valid_in <= 1'b1;
		repeat (48) @(posedge pixel_dot_clock_in);
		#30;
		case (m)
			MODE_M8D:  chk_run(4, exp_data(m, p));
			MODE_TFT1: chk_run(1, exp_data(m, p));
			MODE_C16D: chk_run(3, exp_data(m, p));
			MODE_M16D: chk_run(8, exp_data(m, p));
			MODE_TFT2: chk_run(2, exp_data(m, p));
			MODE_C24D: chk_run(4, exp_data(m, p));
			MODE_C8S:  chk_run(3, exp_data(m, p));
			default:   chk_run(0, exp_data(m, p));
		endcase
		@(posedge pixel_dot_clock_in);
		pix_valid_in <= 1'b0;
		$display("test cfg=%h done", cf);
	endtask

	// ==================================================================
	// main sequence
	initial
	begin
		rst_in = 1'b1;
		reg_addr_in = 4'h0;
		reg_wdata_in = 32'h00000000;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		pix_in = '0;
		pix_valid_in = 1'b0;
		err_total = 0;
		n_tests = 0;
		last_cf = 6'h00;
		void'($urandom(32'h81B1));
		// held in dot cycles so the slow side sees enough edges
		repeat (6) @(posedge pixel_dot_clock_in);
		@(posedge mclk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge pixel_dot_clock_in);
		reg_rd(CFG_ADDR, d0);
		check(d0, 36'h000000000);
		reg_rd(STAT_ADDR, d0);
		check(d0, 36'h000000000);
		reg_wr(4'hC, 32'hFFFFFFFF);
		reg_rd(4'h8, d0);
		check(d0, 36'h000000000);
		reg_rd(CFG_ADDR, d0);
		check(d0, 36'h000000000);
		$display("test reset_regs done");
		// illegal settings are programmed on purpose to see them refused
		for (c = 0; c < 64; c++)
			run_cfg(c[5:0]);
		tally_and_finish();
	end
endmodule // pfs_panel_format_tb_top
